// ===== rtl/ide_bm_channel.sv
// One channel's descriptor walker and word mover
`timescale 1ns/1ns
module ide_bm_channel (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control from the channel's registers
  input wire logic start,
  input wire logic dir,
  input wire logic [31:0] table_ptr,
  // Memory request toward the shared master port
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Drive data side
  input wire logic drv_dreq,
  input wire logic pins_ok,
  input wire logic [15:0] drv_rdata,
  output logic [15:0] drv_wdata,
  output logic drv_wstb,
  output logic drv_ack,
  // State toward the register file and pin arbiter
  output logic pin_need,
  output logic active,
  output logic done
);

  // ----------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------
  ide_bm_pkg::chan_state_e state_r, state_nxt;
  logic start_d_r;            // Start level one cycle ago
  logic [31:0] ptr_r;         // Address of the next descriptor
  logic [31:16] base_hi_r;    // Fixed upper half of the region address
  logic [15:1] addr_lo_r;     // Incrementing part of the region address
  logic [15:0] words_r;       // Words left in the region
  logic last_r;               // Current region is the final one
  logic [15:0] data_r;        // Word in flight
  logic [15:0] drv_wdata_r;
  logic drv_wstb_r;
  logic drv_ack_r;
  logic done_r;

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire start_rise = start & ~start_d_r;
  wire drv_go = (state_r == ide_bm_pkg::CH_DRV) & drv_dreq & pins_ok;
  wire mem_hit = mem_req & mem_ack;
  wire word_done = dir ? ((state_r == ide_bm_pkg::CH_MEM) & mem_ack) : drv_go;
  wire last_word = (words_r == ide_bm_pkg::WORDS_ONE);
  // Zero count means the full 64 KB, i.e. 32768 words
  wire [14:0] cnt_field = mem_rdata[ide_bm_pkg::DESC_CNT_MSB:ide_bm_pkg::DESC_CNT_LSB];
  wire [15:0] cnt_words = {(cnt_field == 15'h0000), cnt_field};
  wire [15:0] rd_half = mem_addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];

  assign mem_req = (state_r == ide_bm_pkg::CH_FETCH_ADDR) | (state_r == ide_bm_pkg::CH_FETCH_CNT)
                 | (state_r == ide_bm_pkg::CH_MEM);
  assign mem_word = (state_r == ide_bm_pkg::CH_MEM);
  assign mem_we = mem_word & dir;
  // Descriptor fetched as two dwords: address first, then count and flag
  assign mem_addr = (state_r == ide_bm_pkg::CH_FETCH_ADDR) ? ptr_r :
                    (state_r == ide_bm_pkg::CH_FETCH_CNT) ? ptr_r + ide_bm_pkg::DESC_CNT_OFS :
                    {base_hi_r, addr_lo_r, 1'b0};
  assign mem_wdata = data_r;
  assign pin_need = (state_r == ide_bm_pkg::CH_DRV);
  assign active = (state_r != ide_bm_pkg::CH_IDLE);
  assign drv_wdata = drv_wdata_r;
  assign drv_wstb = drv_wstb_r;
  assign drv_ack = drv_ack_r;
  assign done = done_r;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ide_bm_pkg::CH_IDLE: begin
        if (start_rise) state_nxt = ide_bm_pkg::CH_FETCH_ADDR;
      end
      ide_bm_pkg::CH_FETCH_ADDR: begin
        if (mem_ack) state_nxt = ide_bm_pkg::CH_FETCH_CNT;
      end
      ide_bm_pkg::CH_FETCH_CNT: begin
        if (mem_ack) state_nxt = dir ? ide_bm_pkg::CH_DRV : ide_bm_pkg::CH_MEM;
      end
      ide_bm_pkg::CH_MEM: begin
        if (mem_ack && !dir) state_nxt = ide_bm_pkg::CH_DRV;
      end
      ide_bm_pkg::CH_DRV: begin
        if (drv_go && dir) state_nxt = ide_bm_pkg::CH_MEM;
      end
      default: state_nxt = ide_bm_pkg::CH_IDLE;
    endcase
    // Region finished: next descriptor only once the count is used up
    if (word_done) begin
      if (!last_word) state_nxt = dir ? ide_bm_pkg::CH_DRV : ide_bm_pkg::CH_MEM;
      else if (last_r) state_nxt = ide_bm_pkg::CH_IDLE;
      else state_nxt = ide_bm_pkg::CH_FETCH_ADDR;
    end
    // Halt on start clear, but never abandon a memory cycle in flight
    if (!start && !(mem_req && !mem_ack)) state_nxt = ide_bm_pkg::CH_IDLE;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ide_bm_pkg::CH_IDLE;
      start_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_d_r <= start;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor and address tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_r <= 32'h0000_0000;
      base_hi_r <= 16'h0000;
      addr_lo_r <= 15'h0000;
      words_r <= 16'h0000;
      last_r <= 1'b0;
    end else begin
      if (state_r == ide_bm_pkg::CH_IDLE && start_rise) ptr_r <= table_ptr;
      if (state_r == ide_bm_pkg::CH_FETCH_ADDR && mem_hit) begin
        base_hi_r <= mem_rdata[31:16];
        addr_lo_r <= mem_rdata[15:1];
      end
      if (state_r == ide_bm_pkg::CH_FETCH_CNT && mem_hit) begin
        words_r <= cnt_words;
        last_r <= mem_rdata[ide_bm_pkg::DESC_LAST_BIT];
        ptr_r <= ptr_r + ide_bm_pkg::DESC_STRIDE;
      end
      // Only bits 15..1 count; the upper half never changes within a region
      if (word_done) begin
        words_r <= words_r - ide_bm_pkg::WORDS_ONE;
        addr_lo_r <= addr_lo_r + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data word and drive strobes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_r <= 16'h0000;
      drv_wdata_r <= 16'h0000;
      drv_wstb_r <= 1'b0;
      drv_ack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (state_r == ide_bm_pkg::CH_MEM && mem_ack && !dir) data_r <= rd_half;
      if (drv_go && dir) data_r <= drv_rdata;
      if (drv_go && !dir) drv_wdata_r <= data_r;
      drv_wstb_r <= drv_go & ~dir;
      drv_ack_r <= drv_go & dir;
      done_r <= word_done & last_word & last_r;
    end
  end

endmodule : ide_bm_channel

// ===== rtl/ide_bm_pkg.sv
// Shared constants and types of the bus-master descriptor DMA engine
package ide_bm_pkg;

  // ----------------------------------------------------------------
  // Register window offsets (byte offsets inside the 16-byte window)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CMD_PRIMARY = 4'h0;
  localparam logic [3:0] OFS_STAT_PRIMARY = 4'h2;
  localparam logic [3:0] OFS_PTR_PRIMARY = 4'h4;
  localparam logic [3:0] OFS_CMD_SECONDARY = 4'h8;
  localparam logic [3:0] OFS_STAT_SECONDARY = 4'ha;
  localparam logic [3:0] OFS_PTR_SECONDARY = 4'hc;
  // Address bit that selects the channel and the one that selects the pointer word
  localparam int ADDR_CHAN_BIT = 3;
  localparam int ADDR_PTR_BIT = 2;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int CMD_DIR_BIT = 3;
  localparam logic [7:0] CMD_WMASK = 8'h69;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_DONE_BIT = 2;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
  localparam logic [31:0] DESC_CNT_OFS = 32'h0000_0004;
  localparam int DESC_LAST_BIT = 31;
  localparam int DESC_CNT_MSB = 15;
  localparam int DESC_CNT_LSB = 1;
  localparam logic [15:0] WORDS_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Channel walker states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CH_IDLE = 5'h01,
    CH_FETCH_ADDR = 5'h02,
    CH_FETCH_CNT = 5'h04,
    CH_MEM = 5'h08,
    CH_DRV = 5'h10
  } chan_state_e;

endpackage : ide_bm_pkg

// ===== rtl/ide_busmaster_prd_dma.sv
// Two-channel bus-master descriptor DMA engine with register window and pin arbiter
// Operation
// - Region length from count bits 15..1, words
// - Region address from bits 31..1, word aligned
// - Separate table pointer for each channel
// - Drive pin mode select for shared pins
// - Grant shared pins to exactly one owner
// - Fetch eight-byte descriptors: address, then count
// - Zero count means a full 64 KB
// - Stop after last descriptor is retired, or on start clear once no memory cycle is in flight
// - Address counter increments bits 1 to 15
// - Sixteen-byte window, byte word dword access
// - Command registers at offsets zero and eight
// - Command holds enable, direction, capability bits
// - Status at offsets two and ten, write-clear
// - Table pointers at offsets four and twelve
// - Direction bit: zero reads, one writes memory
// - Direction bit ignores writes while transfer active
`timescale 1ns/1ns
module ide_busmaster_prd_dma (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register window access
  input wire logic io_sel,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [3:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  output logic io_ack,
  // Memory master port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Drive data, channel c in bits [16c+15:16c]
  input wire logic [1:0] drv_dreq,
  input wire logic [31:0] drv_rdata,
  output logic [31:0] drv_wdata,
  output logic [1:0] drv_wstb,
  output logic [1:0] drv_ack,
  // Shared pin arbitration
  input wire logic isa_req,
  output logic isa_gnt,
  output logic shared_pin_mode_select
);

  // Assertions below that name no clock use this one and sleep in reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Register file storage
  // ----------------------------------------------------------------
  logic [7:0] cmd_r [2];   // Command per channel
  logic [7:0] stat_r [2];  // Status per channel
  logic [31:0] ptr_r [2];  // Table pointer per channel
  logic [31:0] io_rdata_r;
  logic io_ack_r;

  // ----------------------------------------------------------------
  // Channel interconnect
  // ----------------------------------------------------------------
  logic [1:0] ch_req, ch_we, ch_word, ch_ack, ch_need, ch_active, ch_done;
  logic [31:0] ch_addr [2];
  logic [15:0] ch_wdata [2];

  // ----------------------------------------------------------------
  // Memory port and pin arbiter registers
  // ----------------------------------------------------------------
  logic mem_req_r, mem_we_r, owner_r;
  logic [31:0] mem_addr_r, mem_wdata_r;
  logic [3:0] mem_be_r;
  logic pin_ide_r;  // One when the drive side owns the shared pins
  logic isa_gnt_r;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // True when an access hits the given channel and dword
  function automatic logic hit_dword(input logic [3:0] addr, input logic chan, input logic ptr_word);
    hit_dword = (addr[ide_bm_pkg::ADDR_CHAN_BIT] == chan) && (addr[ide_bm_pkg::ADDR_PTR_BIT] == ptr_word);
  endfunction : hit_dword

  wire wr_go = io_sel & io_wr;
  wire rd_go = io_sel & io_rd;
  wire rd_chan = io_addr[ide_bm_pkg::ADDR_CHAN_BIT];
  // Control dword packs command in lane 0 and status in lane 2; lanes 1 and 3 read zero
  wire [31:0] ctl_word = {8'h00, stat_r[rd_chan], 8'h00, cmd_r[rd_chan]};
  wire [31:0] rd_word = io_addr[ide_bm_pkg::ADDR_PTR_BIT] ? ptr_r[rd_chan] : ctl_word;
  wire need_any = |ch_need;
  wire pick = ch_req[~owner_r] ? ~owner_r : owner_r;
  wire [31:0] pick_addr = ch_addr[pick];
  // Fetches move whole dwords, data words use the lane pair named by address bit 1
  wire [3:0] pick_be = !ch_word[pick] ? 4'hf : (pick_addr[1] ? 4'hc : 4'h3);

  // ----------------------------------------------------------------
  // Per-channel registers and walker
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      wire cmd_wr = wr_go & hit_dword(io_addr, c[0], 1'b0) & io_be[0];
      wire stat_wr = wr_go & hit_dword(io_addr, c[0], 1'b0) & io_be[2];
      wire ptr_wr = wr_go & hit_dword(io_addr, c[0], 1'b1);
      wire [7:0] cmd_in = io_wdata[7:0] & ide_bm_pkg::CMD_WMASK;
      wire done_clr = stat_wr & io_wdata[16 + ide_bm_pkg::STAT_DONE_BIT];
      wire [7:0] cmd_nxt = {cmd_in[7:4],
                            ch_active[c] ? cmd_r[c][ide_bm_pkg::CMD_DIR_BIT] : cmd_in[3],
                            cmd_in[2:0]};

      // Command write; direction frozen while the channel runs
      always_ff @(posedge core_clk) begin
        if (reset) cmd_r[c] <= ide_bm_pkg::CMD_RESET;
        else if (cmd_wr) cmd_r[c] <= cmd_nxt;
      end

      // Status: active mirrors the walker, done is sticky and set beats clear
      always_ff @(posedge core_clk) begin
        if (reset) begin
          stat_r[c] <= ide_bm_pkg::STAT_RESET;
        end else begin
          stat_r[c][ide_bm_pkg::STAT_ACTIVE_BIT] <= ch_active[c];
          stat_r[c][ide_bm_pkg::STAT_DONE_BIT] <= ch_done[c]
                                                 | (stat_r[c][ide_bm_pkg::STAT_DONE_BIT] & ~done_clr);
        end
      end

      // Pointer: byte-enabled, low two bits forced to zero for dword alignment
      for (genvar b = 0; b < 4; b = b + 1) begin : g_lane
        always_ff @(posedge core_clk) begin
          if (reset) ptr_r[c][8*b +: 8] <= ide_bm_pkg::PTR_RESET[8*b +: 8];
          else if (ptr_wr && io_be[b]) ptr_r[c][8*b +: 8] <= io_wdata[8*b +: 8] & ((b == 0) ? 8'hfc : 8'hff);
        end
      end

      // Each channel walks its own table from its own pointer
      ide_bm_channel u_chan (
        .core_clk(core_clk),
        .reset(reset),
        .start(cmd_r[c][ide_bm_pkg::CMD_START_BIT]),
        .dir(cmd_r[c][ide_bm_pkg::CMD_DIR_BIT]),
        .table_ptr(ptr_r[c]),
        .mem_req(ch_req[c]),
        .mem_we(ch_we[c]),
        .mem_word(ch_word[c]),
        .mem_addr(ch_addr[c]),
        .mem_wdata(ch_wdata[c]),
        .mem_ack(ch_ack[c]),
        .mem_rdata(mem_rdata),
        .drv_dreq(drv_dreq[c]),
        .pins_ok(pin_ide_r),
        .drv_rdata(drv_rdata[16*c +: 16]),
        .drv_wdata(drv_wdata[16*c +: 16]),
        .drv_wstb(drv_wstb[c]),
        .drv_ack(drv_ack[c]),
        .pin_need(ch_need[c]),
        .active(ch_active[c]),
        .done(ch_done[c])
      );
      assign ch_ack[c] = mem_ack & mem_req_r & (owner_r == c[0]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register read and access acknowledge
  // ----------------------------------------------------------------
  // Every access is answered one cycle later, mapped or not
  always_ff @(posedge core_clk) begin
    if (reset) begin
      io_rdata_r <= 32'h0000_0000;
      io_ack_r <= 1'b0;
    end else begin
      io_ack_r <= rd_go | wr_go;
      if (rd_go) io_rdata_r <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Memory master port
  // ----------------------------------------------------------------
  // Alternates between channels so neither starves; request held until acknowledged
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      owner_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      mem_wdata_r <= 32'h0000_0000;
      mem_be_r <= 4'h0;
    end else if (mem_req_r) begin
      if (mem_ack) mem_req_r <= 1'b0;
    end else if (|ch_req) begin
      mem_req_r <= 1'b1;
      owner_r <= pick;
      mem_we_r <= ch_we[pick];
      mem_addr_r <= pick_addr;
      mem_be_r <= pick_be;
      mem_wdata_r <= {ch_wdata[pick], ch_wdata[pick]};
    end
  end

  // ----------------------------------------------------------------
  // Shared pin arbiter
  // ----------------------------------------------------------------
  // Ownership only changes hands once the holder lets go, so the
  // transceivers never see both sides at once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_ide_r <= 1'b0;
      isa_gnt_r <= 1'b1;
    end else if (pin_ide_r && !need_any && isa_req) begin
      pin_ide_r <= 1'b0;
      isa_gnt_r <= 1'b1;
    end else if (!pin_ide_r && !isa_req && need_any) begin
      pin_ide_r <= 1'b1;
      isa_gnt_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata = io_rdata_r;
  assign io_ack = io_ack_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_be = mem_be_r;
  assign mem_wdata = mem_wdata_r;
  assign isa_gnt = isa_gnt_r;
  assign shared_pin_mode_select = pin_ide_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The pin checks matter most: a slip there lets the isolating
  // transceivers fight the bus side on the shared lines.
  // Memory checks watch the registered port, so a long wait state
  // must never let a request wander before its acknowledge.
  // Register checks pin down the one-cycle answer software relies on.
  sequence s_access;
    io_sel && (io_rd || io_wr);
  endsequence

  sequence s_start_rise;
    $rose(ch_active[0]);
  endsequence

  AST_PIN_EXCLUSIVE: assert property (@(posedge core_clk) disable iff (reset)
    shared_pin_mode_select != isa_gnt)
    else $error("shared pins granted to both or neither side");

  AST_PIN_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
    $fell(shared_pin_mode_select) |-> $past(isa_req) && !$past(need_any))
    else $error("pins left drive mode without an idle drive side and a request");

  AST_IO_ANSWER: assert property (@(posedge core_clk) disable iff (reset)
    s_access |=> io_ack)
    else $error("register access not answered next cycle");

  AST_DIR_LOCK: assert property (@(posedge core_clk) disable iff (reset)
    ch_active[0] && $past(ch_active[0]) |-> $stable(cmd_r[0][ide_bm_pkg::CMD_DIR_BIT]))
    else $error("direction changed while primary channel active");

  AST_FETCH_DWORD: assert property (@(posedge core_clk) disable iff (reset)
    mem_req && mem_be == 4'hf |-> !mem_we && mem_addr[1:0] == 2'b00)
    else $error("descriptor fetch not an aligned dword read");

  AST_WORD_LANES: assert property (@(posedge core_clk) disable iff (reset)
    mem_req && mem_be != 4'hf |-> mem_be == (mem_addr[1] ? 4'hc : 4'h3))
    else $error("data word lanes disagree with address bit 1");

  AST_MEM_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before acknowledge");

  AST_DONE_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    ch_done[0] |=> stat_r[0][ide_bm_pkg::STAT_DONE_BIT] && !ch_active[0])
    else $error("retired table did not set done status");

  AST_DIR_WRITE_MEM: assert property (@(posedge core_clk) disable iff (reset)
    mem_req && mem_we |-> cmd_r[owner_r][ide_bm_pkg::CMD_DIR_BIT])
    else $error("memory write issued with read direction");

  AST_START_FETCH: assert property (@(posedge core_clk) disable iff (reset)
    s_start_rise |-> ##[0:4] (mem_req && mem_addr == ptr_r[0]))
    else $error("start did not fetch from the table pointer");

  // An acknowledge only ever answers an access
  AST_IO_NO_STRAY: assert property (
    io_ack |-> $past(io_sel && (io_rd || io_wr)))
    else $error("register acknowledge without an access");

  // Unmapped bytes of the control dword read zero
  AST_IO_RSVD_ZERO: assert property (
    io_sel && io_rd && !io_addr[2] |=> io_rdata[31:24] == 8'h00 && io_rdata[15:8] == 8'h00)
    else $error("unmapped register byte read nonzero");

  // Bits outside the writable mask stay clear
  AST_CMD_RSVD: assert property (
    (cmd_r[0] & ~ide_bm_pkg::CMD_WMASK) == 8'h00 && (cmd_r[1] & ~ide_bm_pkg::CMD_WMASK) == 8'h00)
    else $error("reserved command bit set");

  // Idle pins go to a waiting drive side at once
  AST_PIN_TAKE: assert property (
    !shared_pin_mode_select && !isa_req && need_any |=> shared_pin_mode_select)
    else $error("idle pins not given to the drive side");

  // No preemption of a busy drive side
  AST_PIN_HOLD: assert property (
    shared_pin_mode_select && need_any |=> shared_pin_mode_select)
    else $error("shared pins taken from a busy drive side");

  // A drive word only moves while the pins are in drive mode
  AST_DRV_PINS: assert property (
    (drv_wstb != 2'b00) || (drv_ack != 2'b00) |-> $past(shared_pin_mode_select))
    else $error("drive word moved while pins in bus mode");

  // A channel moves words one way only
  AST_DRV_ONE_WAY: assert property (
    !(drv_wstb[0] && drv_ack[0]) && !(drv_wstb[1] && drv_ack[1]))
    else $error("drive word sent and taken in one cycle");

  // Clear of primary done with no retire in the same cycle
  sequence s_done_clear;
    wr_go && !io_addr[3] && !io_addr[2] && io_be[2] && io_wdata[18] && !ch_done[0];
  endsequence

  AST_DONE_CLEAR: assert property (
    s_done_clear |=> !stat_r[0][ide_bm_pkg::STAT_DONE_BIT])
    else $error("done status not cleared by software write");

endmodule : ide_busmaster_prd_dma

// ===== test/ide_busmaster_prd_dma_tb.sv
// Self-checking bench of the descriptor DMA engine
`timescale 1ns/1ns
module ide_busmaster_prd_dma_tb;
  logic core_clk, reset, io_sel, io_rd, io_wr, io_ack, isa_req, isa_gnt, shared_pin_mode_select;
  logic mem_req, mem_we, mem_ack;
  logic [3:0] io_addr, io_be, mem_be;
  logic [31:0] io_wdata, io_rdata, mem_addr, mem_wdata, mem_rdata, drv_rdata, drv_wdata, q;
  logic [1:0] drv_dreq, drv_wstb, drv_ack;
  int error_cnt = 0;
  int checked = 0;
  int acks = 0; // Words taken from the secondary drive
  logic [15:0] seen [$]; // Words handed to the primary drive
  ide_busmaster_prd_dma i_dut (.*);
  mem_drive_model i_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (drv_wstb[0]) seen.push_back(drv_wdata[15:0]);
  always @(posedge core_clk) if (drv_ack[1]) acks++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  // One access: request for one cycle, answer in the next
  task automatic io(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk);
    {io_sel, io_rd, io_wr, io_addr, io_be, io_wdata} = {1'b1, !wr, wr, a, be, d};
    @(negedge core_clk);
    io_sel = 1'b0;
    q = io_rdata;
    check({31'h0, io_ack}, 32'h1);
  endtask : io
  // Poll a status bit, bounded
  task automatic wait_stat(input logic [3:0] a, input int b, input logic v);
    io(1'b0, a, 4'hf, 32'h0);
    for (int i = 0; i < 300 && q[b] !== v; i++) io(1'b0, a, 4'hf, 32'h0);
  endtask : wait_stat
  task automatic test_regs();
    check({30'h0, isa_gnt, shared_pin_mode_select}, 32'h2);
    io(1'b0, 4'h0, 4'hf, 32'h0);
    check(q, 32'h0);
    io(1'b1, 4'h4, 4'hf, 32'h0000_0103);
    io(1'b1, 4'hc, 4'h3, 32'h0000_beef);
    io(1'b0, 4'h4, 4'hf, 32'h0);
    check(q, 32'h0000_0100);
    io(1'b0, 4'hc, 4'hf, 32'h0);
    check(q, 32'h0000_beec);
    io(1'b1, 4'h8, 4'hf, 32'hffff_fffe);
    io(1'b0, 4'h9, 4'hf, 32'h0);
    check(q, 32'h0000_0068);
    $display("regs done");
  endtask : test_regs
  // Two regions, the first on the upper word of a dword
  task automatic test_read();
    i_model.mem[8'h40] = 32'h0000_0206;
    i_model.mem[8'h41] = 32'h0000_0002;
    i_model.mem[8'h42] = 32'h0000_0200;
    i_model.mem[8'h43] = 32'h8000_0004;
    i_model.mem[8'h80] = 32'h2222_1111;
    i_model.mem[8'h81] = 32'h4444_3333;
    isa_req = 1'b0;
    io(1'b1, 4'h4, 4'hf, 32'h0000_0100);
    io(1'b1, 4'h0, 4'h1, 32'h0000_0001);
    wait_stat(4'h0, 18, 1'b1);
    io(1'b0, 4'h0, 4'hf, 32'h0);
    check(q, 32'h0004_0001);
    check(32'(seen.size()), 32'h3);
    check({seen[0], seen[1]}, 32'h4444_1111);
    check({16'h0, seen[2]}, 32'h2222);
    check({30'h0, isa_gnt, shared_pin_mode_select}, 32'h1);
    io(1'b1, 4'h0, 4'h5, 32'h0004_0000);
    io(1'b0, 4'h0, 4'hf, 32'h0);
    check(q, 32'h0);
    $display("read done");
  endtask : test_read
  // Zero count region toward memory, halted by software
  task automatic test_write();
    i_model.mem[8'h60] = 32'h0000_0300;
    i_model.mem[8'h61] = 32'h8000_0000;
    i_model.mem[8'hc4] = 32'h0;
    io(1'b1, 4'hc, 4'hf, 32'h0000_0180);
    io(1'b1, 4'h8, 4'h1, 32'h0000_0069);
    wait_stat(4'h8, 16, 1'b1);
    io(1'b1, 4'h8, 4'h1, 32'h0000_0061);
    for (int i = 0; i < 2000 && i_model.mem[8'hc4] !== 32'h5a5a_5a5a; i++) @(negedge core_clk);
    check(i_model.mem[8'hc0], 32'h5a5a_5a5a);
    check(i_model.mem[8'hc4], 32'h5a5a_5a5a);
    check(acks, 32'h0000_000a);
    io(1'b0, 4'h8, 4'hf, 32'h0);
    check(q, 32'h0001_0069);
    io(1'b1, 4'h8, 4'h1, 32'h0000_0068);
    wait_stat(4'h8, 16, 1'b0);
    check(q, 32'h0000_0068);
    io(1'b1, 4'h8, 4'h1, 32'h0000_0060);
    io(1'b0, 4'h8, 4'hf, 32'h0);
    check(q, 32'h0000_0060);
    isa_req = 1'b1;
    repeat (2) @(negedge core_clk);
    check({30'h0, isa_gnt, shared_pin_mode_select}, 32'h2);
    $display("write done");
  endtask : test_write
  task automatic complete_run();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    {reset, io_sel, io_rd, io_wr, isa_req} = 5'b10001;
    {io_addr, io_be, io_wdata} = '0;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    test_regs();
    test_read();
    test_write();
    complete_run();
  end
  // Watchdog, well beyond the expected run
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
endmodule : ide_busmaster_prd_dma_tb

// ===== test/mem_drive_model.sv
// Memory and drive stand-in facing the DMA engine
`timescale 1ns/1ns
module mem_drive_model (
  // Memory port
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Drive side, always ready
  output logic [1:0] drv_dreq,
  output logic [31:0] drv_rdata
);
  logic [31:0] mem [0:255]; // Word store on address bits 9..2
  logic [1:0] dly = 2'h0; // Two wait cycles, so the engine must hold its request
  assign drv_dreq = 2'h3;
  assign drv_rdata = 32'h5a5a_c3c3;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // Slow answer; read data toggles outside an answer so stale values never match
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    dly <= (mem_req && !mem_ack) ? dly + 2'h1 : 2'h0;
    if (mem_req && !mem_ack && dly == 2'h2) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
      for (int i = 0; i < 4; i++)
        if (mem_we && mem_be[i]) mem[mem_addr[9:2]][8*i+:8] <= mem_wdata[8*i+:8];
    end
  end
endmodule : mem_drive_model
